// File: rtl/tppwm_top.sv
// Three-phase center-aligned PWM generator with Wishbone register file.
//
// The implementer's own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
// Summary of operation
// - Resume timing, latch duties at next sync
// - Switching period is unsigned 16 bits
// - Dead time is unsigned 10 bits
// - Sync pulse width is unsigned 10 bits
// - Control bit 4 selects external sync
// - Control bit 3 marks external sync synchronous
// - Control bit 2 selects double update
// - Control bit 1 enables synchronisation
// - Control bit 0 enables; trip clears it
// - Status bit 9 is sync interrupt pending
// - Status bit 8 is trip interrupt pending
// - Status bit 3 shows raw trip level
// - Status bit 0 high while counting down
// - Chop config bit 9 chops low outputs
// - Chop config bit 8 chops high outputs
// - Chop bits 7:0 set carrier period
// - Bits 8..6 cross over phases 0..2
// - Bits 5..0 force outputs off
// - Trip low forces outputs off asynchronously
// - Chop period is four times value plus one
// - Disable after crossover; latched at sync, or at midpoint in double update
// - Chopping disabled after reset
module tppwm_top (
   // Clock, reset and clock enable
   input  wire logic                    clk_i,
   input  wire logic                    rst_i,
   input  wire logic                    ce_i,
   // Wishbone slave
   input  wire tppwm_pkg::tppwm_wb_req_t wb_req_i,
   output tppwm_pkg::tppwm_wb_rsp_t     wb_rsp_o,
   // External sync and fault
   input  wire logic                    ext_sync_i,
   input  wire logic                    fault_trip_input_n_i,
   // Gate outputs, active low (high is off)
   output tppwm_pkg::tppwm_gate_t       gate_n_o,
   output logic                         period_sync_pulse_o
);
   import tppwm_pkg::*;

   // ***********************************************************
   // Register file
   // ***********************************************************
   logic [TPPWM_CON_W-1:0]    control_q;
   logic [TPPWM_PERIOD_W-1:0] period_q;
   logic [TPPWM_DEAD_W-1:0]   dead_q;
   logic [TPPWM_DEAD_W-1:0]   syncw_q;
   logic [TPPWM_CHOP_W-1:0]   chop_q;
   logic [TPPWM_PERIOD_W-1:0] duty_q [3];
   logic [TPPWM_OUTEN_W-1:0]  outen_q;
   logic                      sync_irq_q;
   logic                      trip_irq_q;
   logic [3:0]                armed_q;
   logic                      ack_q;
   logic [31:0]               rdat_q;

   wire req   = wb_req_i.cyc & wb_req_i.stb & ~ack_q;
   // Writes land at the edge where the master samples ack, never earlier.
   wire wr    = wb_req_i.cyc & wb_req_i.stb & ack_q & wb_req_i.we & ce_i;
   wire lo_en = wb_req_i.sel[0];
   wire hi_en = wb_req_i.sel[1];
   wire [15:0] wd = wb_req_i.dat[15:0];
   wire [5:0]  a  = wb_req_i.adr;
   wire w_con  = wr & (a == TPPWM_OFS_CONTROL);
   wire w_sta  = wr & (a == TPPWM_OFS_STATUS);
   wire w_per  = wr & (a == TPPWM_OFS_PERIOD);
   wire w_dead = wr & (a == TPPWM_OFS_DEAD);
   wire w_syw  = wr & (a == TPPWM_OFS_SYNCW);
   wire w_chop = wr & (a == TPPWM_OFS_CHOP);
   wire w_d0   = wr & (a == TPPWM_OFS_DUTY0);
   wire w_d1   = wr & (a == TPPWM_OFS_DUTY1);
   wire w_d2   = wr & (a == TPPWM_OFS_DUTY2);
   wire w_oen  = wr & (a == TPPWM_OFS_OUTEN);

   // Trip: the raw pin is used combinationally for the output kill path.
   wire trip_now = ~fault_trip_input_n_i;

   // ***********************************************************
   // Timing unit
   // ***********************************************************
   logic [TPPWM_PERIOD_W-1:0] cnt_q;
   logic                      down_q;
   logic [TPPWM_PERIOD_W-1:0] act_period_q;
   logic [TPPWM_PERIOD_W-1:0] act_duty_q [3];
   logic [TPPWM_DEAD_W-1:0]   act_dead_q;
   logic [TPPWM_OUTEN_W-1:0]  act_outen_q;
   logic [TPPWM_DEAD_W-1:0]   syncw_cnt_q;
   logic                      ext_sync_q;
   logic                      ext_sync_qq;
   logic                      ext_prev_q;

   wire enabled   = control_q[TPPWM_CON_ENABLE];
   wire running   = enabled & (armed_q == TPPWM_ARM_ALL) & ~trip_now;
   wire dbl_mode  = control_q[TPPWM_CON_DOUBLE];
   // Asynchronous external sync passes two flops; synchronous one is sampled once.
   wire ext_lvl   = control_q[TPPWM_CON_EXTTYPE] ? ext_sync_q : ext_sync_qq;
   wire ext_edge  = ext_lvl & ~ext_prev_q;
   wire use_ext   = control_q[TPPWM_CON_SYNCSEL] & control_q[TPPWM_CON_SYNC_EN];
   wire int_start = down_q ? 1'b0 : (cnt_q >= act_period_q);
   wire start     = running & (use_ext ? ext_edge : int_start);
   wire midpoint  = running & down_q & (cnt_q <= 16'h0001);
   wire load_new  = start | (midpoint & dbl_mode);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ext_sync_q  <= 1'b0;
         ext_sync_qq <= 1'b0;
         ext_prev_q  <= 1'b0;
      end else if (ce_i) begin
         ext_sync_q  <= ext_sync_i;
         ext_sync_qq <= ext_sync_q;
         ext_prev_q  <= ext_lvl;
      end
   end

   // Counter runs from period down to zero (first half), then back up.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q  <= TPPWM_WORD_RST;
         down_q <= 1'b0;
      end else if (ce_i) begin
         if (!running) begin
            cnt_q  <= TPPWM_WORD_RST;
            down_q <= 1'b0;
         end else if (start) begin
            cnt_q  <= period_q;
            down_q <= 1'b1;
         end else if (down_q) begin
            if (cnt_q <= 16'h0001) begin
               down_q <= 1'b0;
               cnt_q  <= TPPWM_WORD_RST;
            end else begin
               cnt_q <= cnt_q - 16'h0001;
            end
         end else if (cnt_q < act_period_q) begin
            cnt_q <= cnt_q + 16'h0001;
         end
      end
   end

   // Shadow values move to the active set only at sync or midpoint.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         act_period_q <= TPPWM_WORD_RST;
         act_dead_q   <= '0;
         act_outen_q  <= TPPWM_OUTEN_RST;
         for (int i = 0; i < 3; i++) begin
            act_duty_q[i] <= TPPWM_WORD_RST;
         end
      end else if (ce_i && load_new) begin
         act_period_q <= period_q;
         act_dead_q   <= dead_q;
         act_outen_q  <= outen_q;
         for (int i = 0; i < 3; i++) begin
            act_duty_q[i] <= duty_q[i];
         end
      end
   end

   // Sync pulse width counter.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         syncw_cnt_q <= '0;
      end else if (ce_i) begin
         if (!running) begin
            syncw_cnt_q <= '0;
         end else if (start) begin
            syncw_cnt_q <= syncw_q;
         end else if (syncw_cnt_q != '0) begin
            syncw_cnt_q <= syncw_cnt_q - 10'h001;
         end
      end
   end
   assign period_sync_pulse_o = (syncw_cnt_q != '0) & ~trip_now;

   // ***********************************************************
   // Phase comparators, crossover, disable and chopping
   // ***********************************************************
   logic [7:0] chop_cnt_q;
   logic [1:0] chop_qtr_q;
   wire chop_clk = chop_qtr_q[1];
   wire [7:0] chop_val = chop_q[7:0];

   // Carrier of 4*(value+1) cycles: two quarter steps high, two low.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         chop_cnt_q <= 8'h00;
         chop_qtr_q <= 2'h0;
      end else if (ce_i) begin
         if (chop_cnt_q >= chop_val) begin
            chop_cnt_q <= 8'h00;
            chop_qtr_q <= chop_qtr_q + 2'h1;
         end else begin
            chop_cnt_q <= chop_cnt_q + 8'h01;
         end
      end
   end

   logic [2:0] raw_hi;
   logic [2:0] raw_lo;
   logic [2:0] x_hi;
   logic [2:0] x_lo;
   logic [5:0] gate_on;
   logic [5:0] gate_on_q;

   // High outputs are active while the counter is under duty and not under dead; low outputs at duty plus dead and above.
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         raw_hi[i] = running & (cnt_q < act_duty_q[i]) &
                     (cnt_q >= {6'h00, act_dead_q});
         raw_lo[i] = running & ({1'b0, cnt_q} >=
                     ({1'b0, act_duty_q[i]} + {7'h00, act_dead_q}));
         x_hi[i]   = act_outen_q[TPPWM_XOVR_LSB+2-i] ? raw_lo[i] : raw_hi[i];
         x_lo[i]   = act_outen_q[TPPWM_XOVR_LSB+2-i] ? raw_hi[i] : raw_lo[i];
         // Disable bits: phase p low at 5-2p, high at 4-2p, after crossover.
         gate_on[3+i] = x_hi[i] & ~act_outen_q[4-2*i]
                        & (~chop_q[TPPWM_CHOP_HI] | chop_clk);
         gate_on[i]   = x_lo[i] & ~act_outen_q[5-2*i]
                        & (~chop_q[TPPWM_CHOP_LO] | chop_clk);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gate_on_q <= 6'h00;
      end else if (ce_i) begin
         gate_on_q <= gate_on;
      end
   end

   // The trip pin gates the registered drive with no clock in the path.
   assign gate_n_o.high = ~(gate_on_q[5:3] & {3{~trip_now}});
   assign gate_n_o.low  = ~(gate_on_q[2:0] & {3{~trip_now}});

   // ***********************************************************
   // Register writes and flags
   // ***********************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         control_q <= TPPWM_CON_RST;
         period_q  <= TPPWM_WORD_RST;
         dead_q    <= '0;
         syncw_q   <= '0;
         chop_q    <= TPPWM_CHOP_RST;
         outen_q   <= TPPWM_OUTEN_RST;
         armed_q   <= 4'h0;
         for (int i = 0; i < 3; i++) begin
            duty_q[i] <= TPPWM_WORD_RST;
         end
      end else if (ce_i) begin
         if (trip_now) begin
            control_q[TPPWM_CON_ENABLE] <= 1'b0;
            armed_q <= 4'h0;
         end else begin
            if (w_con && lo_en) control_q <= wd[TPPWM_CON_W-1:0];
            if (w_per)  armed_q[0] <= 1'b1;
            if (w_d0)   armed_q[1] <= 1'b1;
            if (w_d1)   armed_q[2] <= 1'b1;
            if (w_d2)   armed_q[3] <= 1'b1;
         end
         if (w_per) begin
            if (lo_en) period_q[7:0]  <= wd[7:0];
            if (hi_en) period_q[15:8] <= wd[15:8];
         end
         if (w_dead && lo_en) dead_q[7:0] <= wd[7:0];
         if (w_dead && hi_en) dead_q[9:8] <= wd[9:8];
         if (w_syw && lo_en) syncw_q[7:0] <= wd[7:0];
         if (w_syw && hi_en) syncw_q[9:8] <= wd[9:8];
         if (w_chop && lo_en) chop_q[7:0] <= wd[7:0];
         if (w_chop && hi_en) chop_q[9:8] <= wd[9:8];
         if (w_oen && lo_en) outen_q[7:0] <= wd[7:0];
         if (w_oen && hi_en) outen_q[8]   <= wd[8];
         for (int i = 0; i < 3; i++) begin
            if (((i == 0) ? w_d0 : (i == 1) ? w_d1 : w_d2)) begin
               if (lo_en) duty_q[i][7:0]  <= wd[7:0];
               if (hi_en) duty_q[i][15:8] <= wd[15:8];
            end
         end
      end
   end

   // Flags are cleared by writing one to status; a new event wins over the clear.
   wire clr_sync = w_sta & hi_en & wd[TPPWM_STA_SYNC_IRQ];
   wire clr_trip = w_sta & hi_en & wd[TPPWM_STA_TRIP_IRQ];
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync_irq_q <= 1'b0;
         trip_irq_q <= 1'b0;
      end else if (ce_i) begin
         if (start)         sync_irq_q <= 1'b1;
         else if (clr_sync) sync_irq_q <= 1'b0;
         if (trip_now && enabled) trip_irq_q <= 1'b1;
         else if (clr_trip)       trip_irq_q <= 1'b0;
      end
   end

   // ***********************************************************
   // Read path
   // ***********************************************************
   logic [15:0] rsel;
   always_comb begin
      rsel = 16'h0000;
      if (a == TPPWM_OFS_CONTROL) begin
         rsel = {11'h000, control_q};
      end else if (a == TPPWM_OFS_STATUS) begin
         rsel[TPPWM_STA_SYNC_IRQ] = sync_irq_q;
         rsel[TPPWM_STA_TRIP_IRQ] = trip_irq_q;
         rsel[TPPWM_STA_TRIP_LVL] = fault_trip_input_n_i;
         rsel[TPPWM_STA_HALF]     = down_q;
      end else if (a == TPPWM_OFS_PERIOD) begin
         rsel = period_q;
      end else if (a == TPPWM_OFS_DEAD) begin
         rsel = {6'h00, dead_q};
      end else if (a == TPPWM_OFS_SYNCW) begin
         rsel = {6'h00, syncw_q};
      end else if (a == TPPWM_OFS_CHOP) begin
         rsel = {6'h00, chop_q};
      end else if (a == TPPWM_OFS_DUTY0) begin
         rsel = duty_q[0];
      end else if (a == TPPWM_OFS_DUTY1) begin
         rsel = duty_q[1];
      end else if (a == TPPWM_OFS_DUTY2) begin
         rsel = duty_q[2];
      end else if (a == TPPWM_OFS_OUTEN) begin
         rsel = {7'h00, outen_q};
      end
   end

   // One wait state: ack follows the request by one edge, unmapped reads zero.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q  <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end else if (ce_i) begin
         ack_q  <= req;
         rdat_q <= {16'h0000, rsel};
      end
   end
   assign wb_rsp_o.ack = ack_q;
   assign wb_rsp_o.dat = rdat_q;

   // ***********************************************************
   // Assertions
   // ***********************************************************
   property p_trip_off;
      @(posedge clk_i) disable iff (rst_i)
      trip_now |-> (gate_n_o == 6'h3f) && !period_sync_pulse_o;
   endproperty
   a_trip_off: assert property (p_trip_off) else $error("outputs not off in trip");

   property p_trip_clears_en;
      @(posedge clk_i) disable iff (rst_i)
      (trip_now && ce_i) |=> !control_q[TPPWM_CON_ENABLE]
         && trip_irq_q == ($past(enabled) || ($past(trip_irq_q) && !$past(clr_trip)));
   endproperty
   a_trip_clears_en: assert property (p_trip_clears_en) else $error("trip did not clear enable");

   property p_rearm;
      @(posedge clk_i) disable iff (rst_i)
      ((armed_q != TPPWM_ARM_ALL) && ce_i) |=> (cnt_q == TPPWM_WORD_RST) && !down_q
         && !period_sync_pulse_o;
   endproperty
   a_rearm: assert property (p_rearm) else $error("ran without all writes");

   property p_sync_irq;
      @(posedge clk_i) disable iff (rst_i)
      (start && ce_i) |=> sync_irq_q && down_q;
   endproperty
   a_sync_irq: assert property (p_sync_irq) else $error("sync flag not set");

   property p_phase_bit;
      @(posedge clk_i) disable iff (rst_i)
      (ack_q && $past(a) == TPPWM_OFS_STATUS && $past(ce_i))
         |-> rdat_q[TPPWM_STA_HALF] == $past(down_q);
   endproperty
   a_phase_bit: assert property (p_phase_bit) else $error("phase bit wrong");

   property p_disable;
      @(posedge clk_i) disable iff (rst_i)
      ($past(act_outen_q[5]) && $past(ce_i)) |-> gate_n_o.low[0];
   endproperty
   a_disable: assert property (p_disable) else $error("disabled output active");

   property p_ack_one;
      @(posedge clk_i) disable iff (rst_i)
      (req && ce_i) |=> ack_q ##1 !ack_q;
   endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack not one cycle");

   property p_chop_rst;
      @(posedge clk_i) $past(rst_i) |-> chop_q == TPPWM_CHOP_RST;
   endproperty
   a_chop_rst: assert property (p_chop_rst) else $error("chop not cleared");
endmodule

// File: shared/tppwm_pkg.sv
// Package of register map, field positions, reset values and bus carriers for the PWM block.
package tppwm_pkg;

   // ***********************************************************
   // Register offsets (byte addresses, one aligned word each)
   // ***********************************************************
   localparam logic [5:0] TPPWM_OFS_CONTROL = 6'h00;
   localparam logic [5:0] TPPWM_OFS_STATUS  = 6'h04;
   localparam logic [5:0] TPPWM_OFS_PERIOD  = 6'h08;
   localparam logic [5:0] TPPWM_OFS_DEAD    = 6'h0c;
   localparam logic [5:0] TPPWM_OFS_SYNCW   = 6'h10;
   localparam logic [5:0] TPPWM_OFS_CHOP    = 6'h14;
   localparam logic [5:0] TPPWM_OFS_DUTY0   = 6'h18;
   localparam logic [5:0] TPPWM_OFS_DUTY1   = 6'h1c;
   localparam logic [5:0] TPPWM_OFS_DUTY2   = 6'h20;
   localparam logic [5:0] TPPWM_OFS_OUTEN   = 6'h24;

   // ***********************************************************
   // Field positions
   // ***********************************************************
   localparam int TPPWM_CON_ENABLE   = 0;
   localparam int TPPWM_CON_SYNC_EN  = 1;
   localparam int TPPWM_CON_DOUBLE   = 2;
   localparam int TPPWM_CON_EXTTYPE  = 3;
   localparam int TPPWM_CON_SYNCSEL  = 4;
   localparam int TPPWM_STA_HALF     = 0;
   localparam int TPPWM_STA_TRIP_LVL = 3;
   localparam int TPPWM_STA_TRIP_IRQ = 8;
   localparam int TPPWM_STA_SYNC_IRQ = 9;
   localparam int TPPWM_CHOP_HI      = 8;
   localparam int TPPWM_CHOP_LO      = 9;
   localparam int TPPWM_XOVR_LSB     = 6;

   // ***********************************************************
   // Widths, reset values and timing constants
   // ***********************************************************
   localparam int TPPWM_PERIOD_W = 16;
   localparam int TPPWM_DEAD_W   = 10;
   localparam int TPPWM_CON_W    = 5;
   localparam int TPPWM_CHOP_W   = 10;
   localparam int TPPWM_OUTEN_W  = 9;
   localparam logic [TPPWM_CON_W-1:0]   TPPWM_CON_RST   = 5'h00;
   localparam logic [TPPWM_CHOP_W-1:0]  TPPWM_CHOP_RST  = 10'h000;
   localparam logic [TPPWM_OUTEN_W-1:0] TPPWM_OUTEN_RST = 9'h000;
   localparam logic [TPPWM_PERIOD_W-1:0] TPPWM_WORD_RST = 16'h0000;
   localparam int TPPWM_CHOP_MULT = 4;
   localparam logic [3:0] TPPWM_ARM_ALL = 4'hf;

   // ***********************************************************
   // Carriers
   // ***********************************************************
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [5:0]  adr;
      logic [31:0] dat;
   } tppwm_wb_req_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } tppwm_wb_rsp_t;

   typedef struct packed {
      logic [2:0] high;
      logic [2:0] low;
   } tppwm_gate_t;

endpackage

// File: verification/tppwm_drv_model.sv
// Behavioural gate-driver stage that records what the inverter legs were told.
`timescale 1ns/1ps
module tppwm_drv_model (
   // Clock and clear of the records
   input  wire logic                   clk_i,
   input  wire logic                   clr_i,
   // Gate drive from the block, low is on
   input  wire tppwm_pkg::tppwm_gate_t gate_n_i,
   // Records: outputs ever on, longest phase0 high run, shoot-through seen
   output logic [5:0]                  on_seen_o,
   output logic [7:0]                  run_o,
   output logic                        shoot_o
);
   import tppwm_pkg::*;
   logic [7:0] cur_q;
   logic [7:0] cur_d;
   // A real leg is destroyed by both switches on; the model only remembers it.
   assign cur_d = gate_n_i.high[0] ? 8'h00 : cur_q + 8'h01;
   always_ff @(posedge clk_i) begin
      if (clr_i) begin
         on_seen_o <= 6'h00;
         run_o     <= 8'h00;
         cur_q     <= 8'h00;
         shoot_o   <= 1'b0;
      end else begin
         on_seen_o <= on_seen_o | ~gate_n_i;
         cur_q     <= cur_d;
         run_o     <= (cur_d > run_o) ? cur_d : run_o;
         shoot_o   <= shoot_o | (|(~gate_n_i.high & ~gate_n_i.low));
      end
   end
endmodule

// File: verification/tppwm_top_tb.sv
// Self-checking testbench of the PWM register block and its gate outputs.
`timescale 1ns/1ps
module tppwm_top_tb;
   import tppwm_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ext_sync_i = 1'b0;
   logic trip_n = 1'b1;
   logic clr = 1'b1;
   tppwm_wb_req_t req = '0;
   tppwm_wb_rsp_t rsp;
   tppwm_gate_t   gate_n;
   logic          sync;
   logic [5:0]    seen;
   logic [7:0]    run;
   logic          shoot;
   int n_mismatch = 0;
   int num_checks = 0;
   int cyc_cnt = 0;

   tppwm_top i_tppwm_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_req_i(req),
      .wb_rsp_o(rsp), .ext_sync_i(ext_sync_i), .fault_trip_input_n_i(trip_n),
      .gate_n_o(gate_n), .period_sync_pulse_o(sync));
   tppwm_drv_model i_tppwm_drv_model (.clk_i(clk_i), .clr_i(clr), .gate_n_i(gate_n),
      .on_seen_o(seen), .run_o(run), .shoot_o(shoot));

   initial begin
      forever #2.5 clk_i = ~clk_i;
   end

   // ***********************************************************
   // Shared tasks
   // ***********************************************************
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wb(input logic we, input logic [5:0] a, input logic [15:0] d,
                     output logic [31:0] q);
      @(posedge clk_i);
      req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'h3, adr: a, dat: {16'h0000, d}};
      do @(posedge clk_i); while (rsp.ack !== 1'b1);
      q = rsp.dat;
      req <= '0;
   endtask

   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask

   task automatic wait_sync(input int lim, output logic got, output int w);
      got = 1'b0;
      w = 0;
      repeat (lim) begin
         @(posedge clk_i);
         if (sync === 1'b1) begin
            got = 1'b1;
            break;
         end
      end
      while (got && sync === 1'b1) begin
         w++;
         @(posedge clk_i);
      end
   endtask

   task automatic start_run(input logic [15:0] d0, input logic [15:0] oe);
      wr(TPPWM_OFS_PERIOD, 16'd21);
      wr(TPPWM_OFS_DEAD, 16'd2);
      wr(TPPWM_OFS_SYNCW, 16'd3);
      wr(TPPWM_OFS_OUTEN, oe);
      wr(TPPWM_OFS_DUTY0, d0);
      wr(TPPWM_OFS_DUTY1, 16'd10);
      wr(TPPWM_OFS_DUTY2, 16'd10);
      wr(TPPWM_OFS_CONTROL, 16'h0001);
   endtask

   task automatic watch(input int n);
      repeat (100) @(posedge clk_i);
      clr <= 1'b1;
      @(posedge clk_i);
      clr <= 1'b0;
      repeat (n) @(posedge clk_i);
   endtask

   // ***********************************************************
   // Scenarios
   // ***********************************************************
   task automatic t_regs;
      logic [5:0]  a [7] = '{TPPWM_OFS_CONTROL, TPPWM_OFS_PERIOD, TPPWM_OFS_DEAD,
                             TPPWM_OFS_SYNCW, TPPWM_OFS_CHOP, TPPWM_OFS_OUTEN, 6'h28};
      logic [15:0] m [7] = '{16'h001f, 16'hffff, 16'h03ff, 16'h03ff, 16'h03ff,
                             16'h01ff, 16'h0000};
      logic [31:0] q;
      wb(1'b0, TPPWM_OFS_STATUS, 16'h0000, q);
      chk(q & 32'hfffe, 32'h0000_0008);
      foreach (a[i]) begin
         wb(1'b0, a[i], 16'h0000, q);
         chk(q, 32'h0);
         wr(a[i], 16'hffff);
         wb(1'b0, a[i], 16'h0000, q);
         chk(q, {16'h0000, m[i]});
         wr(a[i], 16'h0000);
      end
   endtask

   task automatic t_run;
      logic [31:0] q;
      logic        got;
      logic [1:0]  half;
      int          w;
      start_run(16'd10, 16'h0000);
      wait_sync(200, got, w);
      chk(got, 1'b1);
      chk(w, 3);
      half = 2'b00;
      repeat (20) begin
         wb(1'b0, TPPWM_OFS_STATUS, 16'h0000, q);
         half[q[TPPWM_STA_HALF]] = 1'b1;
      end
      chk(half, 2'b11);
      chk(q[TPPWM_STA_SYNC_IRQ], 1'b1);
      watch(200);
      chk(run > 8'h04, 1'b1);
      wr(TPPWM_OFS_CHOP, 16'h0101);
      watch(300);
      chk(run, TPPWM_CHOP_MULT * (8'h01 + 1) / 2);
      wr(TPPWM_OFS_CHOP, 16'h0200);
      watch(200);
      chk(seen, 6'h3f);
      wr(TPPWM_OFS_CHOP, 16'h0000);
   endtask

   task automatic t_outen;
      logic [8:0] oe [5] = '{9'h000, 9'h100, 9'h110, 9'h00f, 9'h03f};
      logic [5:0] ex [5] = '{6'h37, 6'h3e, 6'h36, 6'h01, 6'h00};
      foreach (oe[i]) begin
         start_run(16'd0, {7'h00, oe[i]});
         watch(200);
         chk(seen, ex[i]);
         chk(shoot, 1'b0);
      end
      wr(TPPWM_OFS_OUTEN, 16'h0000);
   endtask

   task automatic t_trip;
      logic [31:0] q;
      logic        got;
      int          w;
      start_run(16'd10, 16'h0000);
      repeat (57) @(posedge clk_i);
      trip_n <= 1'b0;
      @(posedge clk_i);
      #1;
      chk({gate_n, sync}, 7'h7e);
      wr(TPPWM_OFS_CONTROL, 16'h0001);
      wb(1'b0, TPPWM_OFS_CONTROL, 16'h0000, q);
      chk(q[TPPWM_CON_ENABLE], 1'b0);
      wb(1'b0, TPPWM_OFS_STATUS, 16'h0000, q);
      chk(q & 32'h0108, 32'h0100);
      trip_n <= 1'b1;
      wr(TPPWM_OFS_STATUS, 16'h0300);
      wb(1'b0, TPPWM_OFS_STATUS, 16'h0000, q);
      chk(q & 32'h0108, 32'h0008);
      wr(TPPWM_OFS_CONTROL, 16'h0001);
      watch(200);
      chk(seen, 6'h00);
      start_run(16'd10, 16'h0000);
      wait_sync(200, got, w);
      chk(got, 1'b1);
   endtask

   task automatic t_ext;
      logic [15:0] con [2] = '{16'h001b, 16'h0013};
      logic        got;
      int          w;
      foreach (con[i]) begin
         wr(TPPWM_OFS_CONTROL, con[i]);
         repeat (60) @(posedge clk_i);
         wait_sync(150, got, w);
         chk(got, 1'b0);
         ext_sync_i <= 1'b1;
         wait_sync(2 + i, got, w);
         chk(got, 1'b0);
         wait_sync(1, got, w);
         ext_sync_i <= 1'b0;
         chk(got, 1'b1);
      end
      wr(TPPWM_OFS_CONTROL, 16'h0005);
      wait_sync(200, got, w);
      chk(got, 1'b1);
      // Disabling all outputs early in the cycle must bite at the midpoint, not the next sync.
      wr(TPPWM_OFS_OUTEN, 16'h003f);
      repeat (17) @(posedge clk_i);
      clr <= 1'b1;
      @(posedge clk_i);
      clr <= 1'b0;
      repeat (12) @(posedge clk_i);
      chk(seen, 6'h00);
   endtask

   // ***********************************************************
   // Main sequence and hang guard
   // ***********************************************************
   always @(posedge clk_i) begin
      cyc_cnt++;
      if (cyc_cnt == 40000) begin
         n_mismatch++;
         wrap_up();
      end
   end

   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      clr <= 1'b0;
      @(posedge clk_i);
      #1;
      chk({gate_n, sync}, 7'h7e);
      t_regs();
      t_run();
      t_outen();
      t_trip();
      t_ext();
      wrap_up();
   end
endmodule
